// >>> rtl/jls_link_status.sv
// Link status register with AXI4-Lite slave
// Assumes status sources arrive asynchronous; frame tick is a one-cycle enable on clk
//
// Functional notes
// - Link flag bit 6 set only after sync, ILAS done and data flowing
// - Request-idle bit 5 low while sync requested or in progress, else high
// - Request-idle follows the sync state machine, not the live pin
// - Phase-adjusted flag bit 4 set when SYSREF shifts frame or multiframe phase
// - SYSREF event without phase change leaves the phase-adjusted flag alone
// - Writing one clears phase-adjusted flag; otherwise it stays set until sample clock loss
// - Loss of sample clock clears both phase-adjusted and alignment flags
// - Alignment flag bit 3 set once a SYSREF event has been processed
// - Rising SYSREF edge counts as the event setting alignment flag
// - Writing one clears alignment flag; otherwise sticky until sample clock loss
// - Read-only bit 2 shows PLL lock
// - Read-only bit 1 shows calibration complete
// - Read-only bit 0 shows an active sample clock input
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "jls_consts.svh"
module jls_link_status #(
  parameter int SYNC_MIN_FRAMES = `JLS_SYNC_MIN_FRAMES
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  // AXI4-Lite write
  input  wire logic [`JLS_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output var  logic                   s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output var  logic                   s_axi_wready,
  output var  logic [1:0]             s_axi_bresp,
  output var  logic                   s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // AXI4-Lite read
  input  wire logic [`JLS_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output var  logic                   s_axi_arready,
  output var  logic [31:0]            s_axi_rdata,
  output var  logic [1:0]             s_axi_rresp,
  output var  logic                   s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // Link and status sources
  input  wire logic                   sync_n,
  input  wire logic                   sysref,
  input  wire logic                   sysref_detect_enable,
  input  wire logic                   frame_tick,
  input  wire logic                   ilas_done,
  input  wire logic                   phase_shift,
  input  wire logic                   pll_locked,
  input  wire logic                   cal_complete,
  input  wire logic                   sample_clock_input,
  // Status out
  output var  logic                   link_up,
  output var  logic                   sysref_aligned
);
  import jls_pkg::*;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  localparam int NS = 7;
  // Resting levels: request line high, so no false request follows reset
  localparam logic [NS-1:0] SYNC_IDLE = {1'b1, {(NS-1){1'b0}}};
  logic [NS-1:0] meta, sync_q, next_meta, next_sync_q;
  always_comb begin
    next_meta   = {sync_n, sysref, ilas_done, phase_shift, pll_locked,
                   cal_complete, sample_clock_input};
    next_sync_q = meta;
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      meta   <= SYNC_IDLE;
      sync_q <= SYNC_IDLE;
    end else begin
      meta   <= next_meta;
      sync_q <= next_sync_q;
    end
  end
  logic s_sync_n, s_sysref, s_ilas, s_shift, s_pll, s_cal, s_clk;
  assign {s_sync_n, s_sysref, s_ilas, s_shift, s_pll, s_cal, s_clk} = sync_q;

  // ----------------------------------------
  // Sync state machine
  // ----------------------------------------
  jls_link_e state, next_state;
  logic [7:0] low_cnt, next_low_cnt;
  logic       sync_req;
  assign sync_req = (low_cnt >= 8'(SYNC_MIN_FRAMES));
  always_comb begin
    next_low_cnt = low_cnt;
    if (s_sync_n)
      next_low_cnt = '0;
    else if (frame_tick && !sync_req)
      next_low_cnt = low_cnt + 8'h01;
    next_state = state;
    case (state)
      JLS_IDLE: begin
        if (sync_req)
          next_state = JLS_SYNCING;
      end
      JLS_SYNCING: begin
        if (s_sync_n)
          next_state = JLS_ILAS;
      end
      JLS_ILAS: begin
        if (sync_req)
          next_state = JLS_SYNCING;
        else if (s_ilas)
          next_state = JLS_DATA;
      end
      JLS_DATA: begin
        if (sync_req)
          next_state = JLS_SYNCING;
      end
      default: next_state = JLS_IDLE;
    endcase
    if (!s_clk)
      next_state = JLS_IDLE;
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state   <= JLS_IDLE;
      low_cnt <= 8'h00;
    end else begin
      state   <= next_state;
      low_cnt <= next_low_cnt;
    end
  end

  // ----------------------------------------
  // Write data capture
  // ----------------------------------------
  // Clear bits held from the W handshake; wdata may change after it
  logic w_clr_phase, w_clr_align, next_w_clr_phase, next_w_clr_align;
  always_comb begin
    next_w_clr_phase = w_clr_phase;
    next_w_clr_align = w_clr_align;
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_clr_phase = s_axi_wstrb[0] && s_axi_wdata[`JLS_BIT_PHASE];
      next_w_clr_align = s_axi_wstrb[0] && s_axi_wdata[`JLS_BIT_ALIGN];
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      w_clr_phase <= 1'b0;
      w_clr_align <= 1'b0;
    end else begin
      w_clr_phase <= next_w_clr_phase;
      w_clr_align <= next_w_clr_align;
    end
  end

  // ----------------------------------------
  // Sticky alignment flags
  // ----------------------------------------
  logic sysref_d, next_sysref_d, phase_flag, next_phase_flag, align_flag, next_align_flag;
  logic wr_fire;
  logic sysref_event;
  assign sysref_event = s_sysref && !sysref_d && sysref_detect_enable && s_cal;
  always_comb begin
    next_sysref_d   = s_sysref;
    next_phase_flag = phase_flag;
    next_align_flag = align_flag;
    // Sets follow clears so a set wins; clock loss overrides both
    if (wr_fire && w_clr_phase)
      next_phase_flag = 1'b0;
    if (wr_fire && w_clr_align)
      next_align_flag = 1'b0;
    if (sysref_event && s_shift)
      next_phase_flag = 1'b1;
    if (sysref_event)
      next_align_flag = 1'b1;
    if (!s_clk) begin
      next_phase_flag = 1'b0;
      next_align_flag = 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sysref_d   <= 1'b0;
      phase_flag <= 1'b0;
      align_flag <= 1'b0;
    end else begin
      sysref_d   <= next_sysref_d;
      phase_flag <= next_phase_flag;
      align_flag <= next_align_flag;
    end
  end

  // ----------------------------------------
  // Status word
  // ----------------------------------------
  jls_stat_t stat;
  always_comb begin
    stat                = '0;
    stat[`JLS_BIT_LINK]  = (state == JLS_DATA);
    stat[`JLS_BIT_IDLE]  = !(sync_req || state == JLS_SYNCING);
    stat[`JLS_BIT_PHASE] = phase_flag;
    stat[`JLS_BIT_ALIGN] = align_flag;
    stat[`JLS_BIT_PLL]   = s_pll;
    stat[`JLS_BIT_CAL]   = s_cal;
    stat[`JLS_BIT_CLK]   = s_clk;
  end

  // ----------------------------------------
  // Status outputs
  // ----------------------------------------
  logic next_link_up, next_aligned;
  always_comb begin
    next_link_up = stat[`JLS_BIT_LINK];
    next_aligned = align_flag;
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      link_up        <= 1'b0;
      sysref_aligned <= 1'b0;
    end else begin
      link_up        <= next_link_up;
      sysref_aligned <= next_aligned;
    end
  end

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  function automatic logic hit(input logic [`JLS_ADDR_W-1:0] a);
    return a == `JLS_LINK_STATUS_ADDR;
  endfunction

  logic aw_ok, w_ok, next_aw_ok, next_w_ok, aw_hit, next_aw_hit;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;
  assign wr_fire = aw_ok && w_ok && !s_axi_bvalid && aw_hit;
  always_comb begin
    next_aw_ok   = aw_ok;
    next_w_ok    = w_ok;
    next_aw_hit  = aw_hit;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_arready = 1'b0;
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_ok  = 1'b1;
      next_aw_hit = hit(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_axi_wready)
      next_w_ok = 1'b1;
    if (aw_ok && w_ok && !s_axi_bvalid) begin
      next_bvalid = 1'b1;
      next_bresp  = aw_hit ? `JLS_RESP_OKAY : `JLS_RESP_SLVERR;
      next_aw_ok  = 1'b0;
      next_w_ok   = 1'b0;
    end
    if (s_axi_bvalid && s_axi_bready)
      next_bvalid = 1'b0;
    next_awready = !next_aw_ok && !next_bvalid;
    next_wready  = !next_w_ok && !next_bvalid;
    if (s_axi_rvalid && s_axi_rready)
      next_rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata  = hit(s_axi_araddr) ? {24'h000000, stat} : 32'h00000000;
      next_rresp  = hit(s_axi_araddr) ? `JLS_RESP_OKAY : `JLS_RESP_SLVERR;
    end else if (!s_axi_arready && !next_rvalid && s_axi_arvalid)
      next_arready = 1'b1;
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      aw_ok          <= 1'b0;
      w_ok           <= 1'b0;
      aw_hit         <= 1'b0;
      s_axi_awready  <= 1'b0;
      s_axi_wready   <= 1'b0;
      s_axi_bvalid   <= 1'b0;
      s_axi_bresp    <= `JLS_RESP_OKAY;
      s_axi_arready  <= 1'b0;
      s_axi_rvalid   <= 1'b0;
      s_axi_rdata    <= 32'h00000000;
      s_axi_rresp    <= `JLS_RESP_OKAY;
    end else begin
      aw_ok          <= next_aw_ok;
      w_ok           <= next_w_ok;
      aw_hit         <= next_aw_hit;
      s_axi_awready  <= next_awready;
      s_axi_wready   <= next_wready;
      s_axi_bvalid   <= next_bvalid;
      s_axi_bresp    <= next_bresp;
      s_axi_arready  <= next_arready;
      s_axi_rvalid   <= next_rvalid;
      s_axi_rdata    <= next_rdata;
      s_axi_rresp    <= next_rresp;
    end
  end
endmodule
`default_nettype wire

// >>> pkg/jls_consts.svh
// Constants for the link status register block
// Assumes inclusion by bare name from the package and the design file
`ifndef JLS_CONSTS_SVH
`define JLS_CONSTS_SVH
`define JLS_ADDR_W           8
`define JLS_LINK_STATUS_ADDR 8'h6C
`define JLS_BIT_LINK         6
`define JLS_BIT_IDLE         5
`define JLS_BIT_PHASE        4
`define JLS_BIT_ALIGN        3
`define JLS_BIT_PLL          2
`define JLS_BIT_CAL          1
`define JLS_BIT_CLK          0
`define JLS_SYNC_MIN_FRAMES  4
`define JLS_RESP_OKAY        2'h0
`define JLS_RESP_SLVERR      2'h2
`endif

// >>> pkg/jls_pkg.sv
// Types for the link status register block
// Assumes jls_consts.svh on the include path
`include "jls_consts.svh"
package jls_pkg;
  typedef enum logic [1:0] {
    JLS_IDLE    = 2'b00,
    JLS_SYNCING = 2'b01,
    JLS_ILAS    = 2'b10,
    JLS_DATA    = 2'b11
  } jls_link_e;
  typedef logic [7:0] jls_stat_t;
endpackage

// >>> sim/jls_link_status_monitor.sv
// Port checker for the link status register block
// Assumes a bind onto jls_link_status
`timescale 1ns/1ps
`default_nettype none
`include "jls_consts.svh"
module jls_link_status_monitor (
  input wire logic        clk, reset_n, sample_clock_input, pll_locked, sysref_aligned,
  input wire logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
  input wire logic        s_axi_rvalid, s_axi_rready,
  input wire logic [1:0]  s_axi_bresp, s_axi_rresp,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic [31:0] s_axi_rdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  clk_loss_a: assert property ($fell(sample_clock_input) |-> ##[1:6] !sysref_aligned)
    else $error("aligned flag kept after clock loss");
  wr_answer_a: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
    else $error("no write response");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  arready_pulse_a: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("arready longer than one cycle");
  rd_answer_a: assert property ((rd_taken and (s_axi_araddr == `JLS_LINK_STATUS_ADDR))
    |-> ##[1:2] s_axi_rvalid && s_axi_rresp == `JLS_RESP_OKAY)
    else $error("no okay read response");
  rd_unmapped_a: assert property ((rd_taken and (s_axi_araddr != `JLS_LINK_STATUS_ADDR))
    |-> ##[1:2] s_axi_rvalid && s_axi_rresp == `JLS_RESP_SLVERR && s_axi_rdata == '0)
    else $error("unmapped read not refused");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped");
  rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:7] == '0)
    else $error("reserved read bits set");
  pll_bit_a: assert property ($rose(s_axi_rvalid) && s_axi_rresp == `JLS_RESP_OKAY
    && $past(pll_locked, 6) == pll_locked |-> s_axi_rdata[2] == pll_locked)
    else $error("lock bit wrong");
endmodule
`default_nettype wire

// >>> sim/jls_rx_model.sv
// Receiver side model: request line, shared sysref source, frame tick
// Assumes the bench commands requests and sysref pulses
`timescale 1ns/1ps
`default_nettype none
module jls_rx_model (
  input wire logic clk, req, blip, fire,
  output var logic sync_n, sysref, frame_tick
);
  logic [1:0] div = 2'h0;
  always @(posedge clk) begin
    div <= div + 2'h1;
    frame_tick <= (div == 2'h3);
    sync_n <= !(req || blip);
    sysref <= fire;
  end
endmodule
`default_nettype wire

// >>> sim/jls_link_status_tb.sv
// Self-checking bench for the link status register block
// Assumes the receiver model and the bound checker
`timescale 1ns/1ps
`default_nettype none
`include "jls_consts.svh"
module jls_link_status_tb;
  import jls_pkg::*;
  logic        clk = 0, reset_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, req = 0, blip = 0, fire = 0;
  logic        sysref_detect_enable = 0, ilas_done = 0, phase_shift = 0, pll_locked = 1;
  logic        cal_complete = 0, sample_clock_input = 1;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, got;
  logic [3:0]  s_axi_wstrb = '0;
  logic [1:0]  rs;
  wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic   link_up, sysref_aligned, sync_n, sysref, frame_tick;
  wire logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  int          num_errors = 0, n_tests = 0;
  jls_link_status #(.SYNC_MIN_FRAMES(2)) uut (.*);
  jls_rx_model rx (.*);
  initial forever #5 clk = ~clk;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic settle;
    repeat (8) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st,
                    input int lag);
    logic aw_on = 1'b1;
    logic w_on  = 1'b1;
    logic done  = 1'b0;
    int   n     = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (lag == 0);
    while (!done) begin
      @(posedge clk);
      n++;
      if (aw_on && s_axi_awready) begin
        aw_on = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_on && s_axi_wready) begin
        w_on = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end else if (n == lag)
        s_axi_bready <= 1'b1;
    end
    @(posedge clk);
  endtask
  task automatic rdx(input logic [7:0] a, input int lag);
    logic ar_on = 1'b1;
    logic done  = 1'b0;
    int   n     = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (lag == 0);
    while (!done) begin
      @(posedge clk);
      n++;
      if (ar_on && s_axi_arready) begin
        ar_on = 1'b0;
        s_axi_arvalid <= 1'b0;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        got = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end else if (n == lag)
        s_axi_rready <= 1'b1;
    end
    @(posedge clk);
  endtask
  task automatic look(input logic [31:0] e);
    rdx(`JLS_LINK_STATUS_ADDR, 0);
    chk(got, e);
    chk({30'h0, rs}, {30'h0, `JLS_RESP_OKAY});
  endtask
  task automatic pulse(input logic p);
    phase_shift <= p;
    fire <= 1'b1;
    repeat (3) @(posedge clk);
    fire <= 1'b0;
    settle();
    phase_shift <= 1'b0;
  endtask
  task automatic t_status;
    look(32'h25);
    cal_complete <= 1'b1;
    settle();
    look(32'h27);
    pll_locked <= 1'b0;
    settle();
    look(32'h23);
    pll_locked <= 1'b1;
    settle();
  endtask
  task automatic t_sync;
    blip <= 1'b1;
    @(posedge clk);
    blip <= 1'b0;
    settle();
    look(32'h27);
    req <= 1'b1;
    repeat (40) @(posedge clk);
    look(32'h07);
    req <= 1'b0;
    settle();
    look(32'h27);
    ilas_done <= 1'b1;
    settle();
    look(32'h67);
    chk({31'h0, link_up}, 32'h1);
  endtask
  task automatic t_sysref;
    sysref_detect_enable <= 1'b1;
    pulse(1'b0);
    look(32'h6F);
    chk({31'h0, sysref_aligned}, 32'h1);
    pulse(1'b1);
    look(32'h7F);
    wr(`JLS_LINK_STATUS_ADDR, 32'h10, 4'hF, 0);
    chk({30'h0, rs}, {30'h0, `JLS_RESP_OKAY});
    look(32'h6F);
    wr(`JLS_LINK_STATUS_ADDR, 32'h08, 4'hF, 0);
    look(32'h67);
  endtask
  task automatic t_clkloss;
    pulse(1'b1);
    look(32'h7F);
    sample_clock_input <= 1'b0;
    settle();
    look(32'h26);
    chk({31'h0, sysref_aligned}, 32'h0);
    sample_clock_input <= 1'b1;
    settle();
  endtask
  task automatic t_unmapped;
    pulse(1'b1);
    rdx(8'h70, 4);
    chk(got, 32'h0);
    chk({30'h0, rs}, {30'h0, `JLS_RESP_SLVERR});
    wr(8'h70, 32'h18, 4'hF, 4);
    chk({30'h0, rs}, {30'h0, `JLS_RESP_SLVERR});
    look(32'h3F);
    wr(`JLS_LINK_STATUS_ADDR, 32'h18, 4'h0, 0);
    chk({30'h0, rs}, {30'h0, `JLS_RESP_OKAY});
    look(32'h3F);
    wr(`JLS_LINK_STATUS_ADDR, 32'h18, 4'hF, 0);
    look(32'h27);
  endtask
  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    settle();
    t_status();
    t_sync();
    t_sysref();
    t_clkloss();
    t_unmapped();
    conclude();
  end
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    conclude();
  end
endmodule
bind jls_link_status jls_link_status_monitor mon (.*);
`default_nettype wire
